// ### hw/atc_trigger_ctrl.sv
/*
 * Acquisition trigger control: acquisition start/stop, internal legacy
 * trigger generation with rate limit, hardware frame start trigger with
 * edge choice, delay, timed or pulse-width exposure and overtrigger.
 * Assumes the host holds configuration stable while acquisition runs and
 * that the trigger input is asynchronous to I_CLK.
 */
// Notes on behaviour
// RULE1: first power-up runs acquisition control in legacy mode.
// RULE2: legacy start trigger acts as the frame start trigger.
// RULE3: while waiting, each start trigger starts one frame.
// RULE4: host sets acquisition mode, then issues acquisition start.
// RULE5: start trigger mode is off or on.
// RULE6: mode off means triggers are made internally.
// RULE7: mode off, one-shot: one internal trigger per start command.
// RULE8: mode off, free-running: triggers continue until stop command.
// RULE9: rate limit disabled: trigger at maximum allowed rate.
// RULE10: rate limit enabled and slower: trigger at programmed rate.
// RULE11: rate limit faster than maximum: clamp to maximum rate.
// RULE12: start triggers count only while waiting.
// RULE13: mode off: exposure length comes from exposure setting.
// RULE14: rising edge, timed: frame starts when input goes high.
// RULE15: hardware frame trigger delayed by programmable microseconds.
// RULE16: rate limit disabled: rate follows external triggers.
// RULE17: host sets exposure setting to shortest pulse-width exposure.
// RULE18: trigger during timed exposure ignored, overtrigger raised.
// RULE19: pulse-width exposure runs from active to opposite edge.
// RULE20: triggers outside waiting status are dropped, never queued.
`default_nettype none
`include "atc_defines.svh"

module atc_trigger_ctrl
	import atc_pkg::*;
(
	// clock and reset
	input  wire logic                I_CLK,
	input  wire logic                I_RST_B,
	// host commands and settings
	input  wire logic                i_acq_start,
	input  wire logic                i_acq_stop,
	input  wire atc_pkg::atc_cfg_t   i_cfg,
	// trigger line from outside
	input  wire logic                i_external_frame_trigger_input,
	// status and events
	output atc_pkg::atc_status_t     o_status,
	output logic                     o_legacy_active
);
	import atc_pkg::*;

	typedef enum logic [2:0] { ATC_IDLE, ATC_WAIT, ATC_DELAY, ATC_EXPOSE,
		ATC_HOLD } atc_state_t;

	////////////////////////////////////////////////////////////////////////
	// input synchroniser and edge detect
	logic sync_a;
	logic sync_b;
	logic line_q;

	always_ff @(posedge I_CLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
		begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			line_q <= 1'b0;
		end
		else
		begin
			sync_a <= i_external_frame_trigger_input;
			sync_b <= sync_a;
			line_q <= sync_b;
		end
	end

	function automatic logic edge_hit(input logic now, input logic was,
		input atc_edge_t sel);
		edge_hit = (sel == ATC_EDGE_RISING) ? (now & ~was) : (~now & was);
	endfunction

	logic active_edge;
	logic opposite_edge;
	atc_edge_t other_sel;
	assign other_sel     = (i_cfg.trigger_edge_select == ATC_EDGE_RISING) ?
		ATC_EDGE_FALLING : ATC_EDGE_RISING;
	// RULE14: selected edge starts frame
	assign active_edge   = edge_hit(sync_b, line_q, i_cfg.trigger_edge_select);
	assign opposite_edge = edge_hit(sync_b, line_q, other_sel);

	////////////////////////////////////////////////////////////////////////
	// legacy mode flag
	logic legacy;
	// RULE1: legacy after reset
	always_ff @(posedge I_CLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
			legacy <= 1'b1;
		else
			legacy <= i_cfg.legacy_mode;
	end

	////////////////////////////////////////////////////////////////////////
	// internal trigger rate
	function automatic logic [`ATC_PERIOD_W-1:0] pick_period(input atc_cfg_t c);
		// RULE9: unlimited runs at maximum rate
		if (!c.frame_rate_limit_enable)
			pick_period = c.max_rate_period;
		// RULE11: clamp faster request to maximum
		else if (c.frame_rate_limit_period < c.max_rate_period)
			pick_period = c.max_rate_period;
		// RULE10: programmed rate when slower
		else
			pick_period = c.frame_rate_limit_period;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// main sequencer
	atc_state_t             state;
	atc_state_t             next_state;
	logic                   running;
	logic                   next_running;
	logic [`ATC_PERIOD_W-1:0] rate_cnt;
	logic [`ATC_PERIOD_W-1:0] next_rate_cnt;
	logic                   fired;
	logic                   next_fired;
	logic                   frame_start;
	logic                   next_frame_start;
	logic                   overtrig;
	logic                   next_overtrig;

	logic                   delay_load;
	logic                   exp_load;
	logic                   delay_done;
	logic                   exp_busy;
	logic                   exp_done;
	logic                   internal_src;
	logic                   rate_ok;
	logic                   trig;

	// RULE2: in legacy the start trigger is the frame trigger
	// RULE5: start trigger mode off or on
	assign internal_src = legacy ? ~i_cfg.start_trigger_mode_on :
		~i_cfg.frame_trigger_mode_on;
	// period ends in the cycle the counter reads one
	assign rate_ok      = (rate_cnt <= `ATC_ONE_CNT);
	// RULE6: internal trigger when mode off
	// RULE7: one-shot gives a single trigger
	// RULE16: line triggers bypass rate counter
	assign trig = internal_src ? (running && rate_ok &&
		!(i_cfg.acq_mode == ATC_ONE_SHOT && fired)) : active_edge;

	atc_us_timer u_delay
	(
		.i_clk  (I_CLK),
		.i_rst_b(I_RST_B),
		.i_load (delay_load),
		.i_us   (i_cfg.trigger_delay_us),
		.o_busy (),
		.o_done (delay_done)
	);

	atc_us_timer u_expose
	(
		.i_clk  (I_CLK),
		.i_rst_b(I_RST_B),
		.i_load (exp_load),
		.i_us   (i_cfg.exposure_time_setting),
		.o_busy (exp_busy),
		.o_done (exp_done)
	);

	always_comb
	begin
		next_state       = state;
		next_running     = running;
		next_rate_cnt    = (rate_cnt == `ATC_ZERO_CNT) ? rate_cnt :
			rate_cnt - `ATC_ONE_CNT;
		next_fired       = fired;
		next_frame_start = 1'b0;
		next_overtrig    = 1'b0;
		delay_load       = 1'b0;
		exp_load         = 1'b0;
		// RULE8: run until stop command
		if (i_acq_stop)
			next_running = 1'b0;
		else if (i_acq_start)
		begin
			next_running = 1'b1;
			next_fired   = 1'b0;
		end
		unique case (state)
			ATC_IDLE:
				if (next_running)
					next_state = ATC_WAIT;
			ATC_WAIT:
				// RULE3: one frame per trigger
				// RULE12: triggers act only here
				if (!running)
					next_state = ATC_IDLE;
				else if (trig)
				begin
					next_fired    = 1'b1;
					next_rate_cnt = pick_period(i_cfg);
					if (!internal_src)
					begin
						// RULE15: hardware trigger delayed
						delay_load = 1'b1;
						next_state = ATC_DELAY;
					end
					else
					begin
						// RULE13: exposure from setting
						exp_load         = 1'b1;
						next_frame_start = 1'b1;
						next_state       = ATC_EXPOSE;
					end
				end
			ATC_DELAY:
				if (delay_done)
				begin
					exp_load         = 1'b1;
					next_frame_start = 1'b1;
					next_state       = (!internal_src &&
						i_cfg.exp_mode == ATC_EXP_PULSE_WIDTH) ? ATC_HOLD :
						ATC_EXPOSE;
				end
			ATC_EXPOSE:
			begin
				// RULE18: overtrigger while exposing
				// RULE20: dropped, not queued
				if (!internal_src && active_edge &&
					i_cfg.exp_mode == ATC_EXP_TIMED)
					next_overtrig = 1'b1;
				if (exp_done)
					next_state = next_running ? ATC_WAIT : ATC_IDLE;
			end
			ATC_HOLD:
				// RULE19: expose until opposite edge
				if (opposite_edge)
					next_state = next_running ? ATC_WAIT : ATC_IDLE;
			default:
				next_state = ATC_IDLE;
		endcase
	end

	always_ff @(posedge I_CLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
		begin
			state       <= ATC_IDLE;
			running     <= 1'b0;
			rate_cnt    <= `ATC_ZERO_CNT;
			fired       <= 1'b0;
			frame_start <= 1'b0;
			overtrig    <= 1'b0;
		end
		else
		begin
			state       <= next_state;
			running     <= next_running;
			rate_cnt    <= next_rate_cnt;
			fired       <= next_fired;
			frame_start <= next_frame_start;
			overtrig    <= next_overtrig;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign o_status = '{
		waiting:     (state == ATC_WAIT),
		exposing:    (state == ATC_EXPOSE) || (state == ATC_HOLD),
		frame_start: frame_start,
		overtrigger: overtrig
	};
	assign o_legacy_active      = legacy;
endmodule

`default_nettype wire

// ### common/atc_defines.svh
/*
 * Constants for the acquisition trigger control: field widths, reset values,
 * timing figures in their own units and the cycle counts derived from them.
 * Assumes a single 25 MHz clock.
 */
`ifndef ATC_DEFINES_SVH
`define ATC_DEFINES_SVH

`define ATC_CLK_MHZ          25
`define ATC_US_W             20
`define ATC_PERIOD_W         32
`define ATC_CNT_W            32
`define ATC_CYC_PER_US       (`ATC_CLK_MHZ)
`define ATC_DELAY_DEFAULT_US 20'h0_03E8
`define ATC_ZERO_US          20'h0_0000
`define ATC_ZERO_CNT         32'h0000_0000
`define ATC_ONE_CNT          32'h0000_0001

`endif

// ### common/atc_pkg.sv
/*
 * Types for the acquisition trigger control.
 * Assumes atc_defines.svh is on the include path.
 */
`default_nettype none
`include "atc_defines.svh"

package atc_pkg;

	typedef enum logic { ATC_ONE_SHOT, ATC_FREE_RUNNING } atc_acq_mode_t;
	typedef enum logic { ATC_EDGE_RISING, ATC_EDGE_FALLING } atc_edge_t;
	typedef enum logic { ATC_EXP_TIMED, ATC_EXP_PULSE_WIDTH } atc_exp_mode_t;

	typedef struct packed {
		logic                      legacy_mode;
		atc_acq_mode_t             acq_mode;
		logic                      start_trigger_mode_on;
		logic                      frame_trigger_mode_on;
		atc_edge_t                 trigger_edge_select;
		atc_exp_mode_t             exp_mode;
		logic                      frame_rate_limit_enable;
		logic [`ATC_PERIOD_W-1:0]  frame_rate_limit_period;
		logic [`ATC_PERIOD_W-1:0]  max_rate_period;
		logic [`ATC_US_W-1:0]      exposure_time_setting;
		logic [`ATC_US_W-1:0]      trigger_delay_us;
	} atc_cfg_t;

	typedef struct packed {
		logic waiting;
		logic exposing;
		logic frame_start;
		logic overtrigger;
	} atc_status_t;

endpackage

`default_nettype wire

// ### hw/atc_us_timer.sv
/*
 * Microsecond-programmed one-shot timer: load starts it, done pulses once.
 * Assumes load is a single-cycle pulse on the same clock.
 */
`default_nettype none
`include "atc_defines.svh"

module atc_us_timer
(
	// clock and reset
	input  wire logic                  i_clk,
	input  wire logic                  i_rst_b,
	// control
	input  wire logic                  i_load,
	input  wire logic [`ATC_US_W-1:0]  i_us,
	// result
	output logic                       o_busy,
	output logic                       o_done
);
	logic [`ATC_CNT_W-1:0] cnt;
	logic [`ATC_CNT_W-1:0] next_cnt;
	logic                  busy;
	logic                  next_busy;
	logic                  last;

	// done shows in the final counted cycle, so the count is exact
	assign last = busy && (cnt <= `ATC_ONE_CNT);

	always_comb
	begin
		next_cnt  = cnt;
		next_busy = busy;
		if (i_load)
		begin
			next_cnt  = `ATC_CNT_W'(i_us) * `ATC_CNT_W'(`ATC_CYC_PER_US);
			next_busy = 1'b1;
		end
		else if (last)
		begin
			next_busy = 1'b0;
			next_cnt  = `ATC_ZERO_CNT;
		end
		else if (busy)
			next_cnt = cnt - `ATC_ONE_CNT;
	end

	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			cnt  <= `ATC_ZERO_CNT;
			busy <= 1'b0;
		end
		else
		begin
			cnt  <= next_cnt;
			busy <= next_busy;
		end
	end

	assign o_busy = busy;
	assign o_done = last;
endmodule

`default_nettype wire

// ### bench/atc_checker.sv
/* port assertions for the trigger control
   bound to atc_trigger_ctrl from the bench top */
`default_nettype none
`include "atc_defines.svh"
module atc_checker
	import atc_pkg::*;
(
	// clock and reset
	input  wire logic                 I_CLK,
	input  wire logic                 I_RST_B,
	// commands and settings
	input  wire logic                 i_acq_start,
	input  wire logic                 i_acq_stop,
	input  wire atc_pkg::atc_cfg_t    i_cfg,
	// status
	input  wire atc_pkg::atc_status_t o_status,
	input  wire logic                 o_legacy_active
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_RST_B);
	logic [31:0] ecnt, next_ecnt, gap, next_gap, per;
	logic        fired, next_fired, intl, pw;
	assign intl = i_cfg.legacy_mode & ~i_cfg.start_trigger_mode_on;
	assign pw = (i_cfg.legacy_mode ? i_cfg.start_trigger_mode_on : i_cfg.frame_trigger_mode_on)
		& (i_cfg.exp_mode == ATC_EXP_PULSE_WIDTH);
	assign per = (i_cfg.frame_rate_limit_enable
		&& i_cfg.frame_rate_limit_period > i_cfg.max_rate_period)
		? i_cfg.frame_rate_limit_period : i_cfg.max_rate_period;
	////////////////////////////////////////////////////////////////
	always_comb
	begin
		next_ecnt = o_status.exposing ? ecnt + 32'h0000_0001 : 32'h0000_0000;
		next_gap = (i_acq_start | o_status.frame_start) ? 32'h0000_0000 : gap + 32'h0000_0001;
		next_fired = ~i_acq_start & (fired | o_status.frame_start);
	end
	always_ff @(posedge I_CLK or negedge I_RST_B)
		if (!I_RST_B)
			{ecnt, gap, fired} <= '0;
		else
			{ecnt, gap, fired} <= {next_ecnt, next_gap, next_fired};
	////////////////////////////////////////////////////////////////
	AST_LEGACY: assert property (o_legacy_active == $past(i_cfg.legacy_mode))
		else $error("legacy flag wrong");
	AST_FS_PULSE: assert property (o_status.frame_start |=> !o_status.frame_start)
		else $error("frame start too long");
	AST_FS_EXP: assert property (o_status.frame_start |-> o_status.exposing && !o_status.waiting)
		else $error("frame start without exposure");
	AST_EXCL: assert property (!(o_status.waiting && o_status.exposing))
		else $error("waiting while exposing");
	AST_OVT: assert property (o_status.overtrigger |-> $past(o_status.exposing))
		else $error("overtrigger outside exposure");
	AST_TIMED: assert property ($fell(o_status.exposing) && !pw
		|-> ecnt == i_cfg.exposure_time_setting * `ATC_CYC_PER_US)
		else $error("exposure length wrong");
	AST_ONE_SHOT: assert property (o_status.frame_start && intl
		&& i_cfg.acq_mode == ATC_ONE_SHOT |-> !fired)
		else $error("second one-shot frame");
	AST_RATE: assert property (o_status.frame_start && fired && intl
		&& i_cfg.acq_mode == ATC_FREE_RUNNING |-> gap == per - 32'h0000_0001)
		else $error("internal trigger spacing wrong");
	AST_STOP: assert property (i_acq_stop && !o_status.exposing |-> ##[1:4] !o_status.waiting)
		else $error("stop not taken");
endmodule
`default_nettype wire

// ### bench/atc_trig_src.sv
/* external trigger source driving the frame trigger line
   driven by bench calls, one clock shared with the design */
`default_nettype none
module atc_trig_src
(
	// clock
	input  wire logic I_CLK,
	// trigger line
	output logic      o_line
);
	timeunit 1ns;
	timeprecision 1ps;
	logic idle = 1'b0;
	task automatic pulse(input int hi);
		@(posedge I_CLK);
		o_line <= ~idle;
		repeat (hi) @(posedge I_CLK);
		o_line <= idle;
	endtask
	task automatic set_idle(input logic v);
		@(posedge I_CLK);
		idle = v;
		o_line <= v;
	endtask
	initial o_line = 1'b0;
endmodule
`default_nettype wire

// ### bench/atc_trigger_ctrl_tb.sv
/* bench top: clock, reset, host tasks and tests
   assumes the checker and trigger source are compiled first */
`default_nettype none
module atc_trigger_ctrl_tb import atc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst_b, start, stop, leg, line;
	atc_cfg_t    cfg, nc;
	atc_status_t st;
	int          err_total, check_count, n, m;
	int          lim [3] = '{0, 200, 50};
	int          gexp [3] = '{100, 200, 100};
	atc_trigger_ctrl atc_trigger_ctrl_i (.I_CLK(clk), .I_RST_B(rst_b), .i_acq_start(start),
		.i_acq_stop(stop), .i_cfg(cfg), .i_external_frame_trigger_input(line),
		.o_status(st), .o_legacy_active(leg));
	atc_trig_src atc_trig_src_i (.I_CLK(clk), .o_line(line));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] s, e);
		check_count++;
		if (s !== e)
		begin
			err_total++;
			$display("ERROR %s expected %0h seen %0h", nm, e, s);
		end
	endtask
	task automatic cmd(input bit s);
		@(posedge clk);
		if (s) stop <= 1'b1;
		else start <= 1'b1;
		@(posedge clk);
		stop <= 1'b0;
		start <= 1'b0;
	endtask
	task automatic setcfg();
		@(posedge clk);
		cfg <= nc;
	endtask
	task automatic wait_fs(input int lim, output int k);
		k = 0;
		do
		begin
			@(negedge clk);
			k++;
		end while (st.frame_start !== 1'b1 && k < lim);
	endtask
	task automatic exp_len(output int k);
		k = 0;
		while (st.exposing === 1'b1 && k < 999)
		begin
			k++;
			@(negedge clk);
		end
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial
	begin
		repeat (60000) @(posedge clk);
		err_total++;
		close_out();
	end
	initial
	begin
		err_total = 0;
		check_count = 0;
		rst_b = 1'b0;
		start = 1'b0;
		stop = 1'b0;
		nc = '0;
		nc.legacy_mode = 1'b1;
		nc.max_rate_period = 32'h0000_0064;
		nc.exposure_time_setting = 20'h0_0001;
		cfg = nc;
		repeat (10) @(posedge clk);
		chk("reset", {st, leg}, 32'h0000_0001);
		rst_b <= 1'b1;
		cmd(0);
		wait_fs(20, n);
		chk("first", st.frame_start, 1);
		exp_len(m);
		chk("exposure", m, 25);
		wait_fs(300, n);
		chk("once", n, 300);
		cmd(1);
		$display("test 1 done");
		nc.acq_mode = ATC_FREE_RUNNING;
		for (int i = 0; i < 3; i++)
		begin
			nc.frame_rate_limit_enable = (i != 0);
			nc.frame_rate_limit_period = lim[i];
			setcfg();
			cmd(0);
			wait_fs(400, n);
			wait_fs(400, n);
			chk("gap", n, gexp[i]);
			cmd(1);
			wait_fs(400, n);
			chk("stopped", n, 400);
		end
		$display("test 2 done");
		nc.start_trigger_mode_on = 1'b1;
		nc.frame_trigger_mode_on = 1'b1;
		nc.trigger_delay_us = 20'h0_0002;
		nc.exposure_time_setting = 20'h0_0004;
		setcfg();
		fork atc_trig_src_i.pulse(5); wait_fs(100, n); join
		chk("idle", n, 100);
		cmd(0);
		repeat (4) @(negedge clk);
		fork atc_trig_src_i.pulse(10); wait_fs(80, n); join
		chk("delay", n >= 50 && n <= 60, 1);
		m = 0;
		fork
			atc_trig_src_i.pulse(5);
			while (st.overtrigger !== 1'b1 && m < 20)
			begin
				@(negedge clk);
				m++;
			end
		join
		chk("overtrigger", m < 20, 1);
		wait_fs(200, n);
		chk("dropped", n, 200);
		cmd(1);
		$display("test 3 done");
		nc.exp_mode = ATC_EXP_PULSE_WIDTH;
		nc.trigger_edge_select = ATC_EDGE_FALLING;
		nc.trigger_delay_us = 20'h0_0000;
		nc.exposure_time_setting = 20'h0_0001;
		setcfg();
		atc_trig_src_i.set_idle(1'b1);
		cmd(0);
		repeat (8) @(negedge clk);
		fork atc_trig_src_i.pulse(100); begin wait_fs(20, n); exp_len(m); end join
		chk("width", m >= 90 && m <= 104, 1);
		$display("test 4 done");
		cmd(1);
		nc.legacy_mode = 1'b0;
		nc.start_trigger_mode_on = 1'b0;
		setcfg();
		cmd(0);
		wait_fs(100, n);
		chk("legacy off", leg, 0);
		chk("no internal", n, 100);
		fork atc_trig_src_i.pulse(30); begin wait_fs(20, n); exp_len(m); end join
		chk("std width", m >= 25 && m <= 34, 1);
		$display("test 5 done");
		close_out();
	end
endmodule
bind atc_trigger_ctrl atc_checker atc_checker_i (.I_CLK(I_CLK), .I_RST_B(I_RST_B),
	.i_acq_start(i_acq_start), .i_acq_stop(i_acq_stop), .i_cfg(i_cfg),
	.o_status(o_status), .o_legacy_active(o_legacy_active));
`default_nettype wire
